// ### dv/line_lane_mapping_and_system_control_tb.sv
module line_lane_mapping_and_system_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk = 0, i_arst_n = 1, fl_n = 1, mode = 0, byp = 1, proc = 1, pm = 0;
   logic psel = 0, penable = 0, pwrite = 0, txc, txf, e, dck, dck_oe, oe, take, dci = 0;
   logic pbyp, psync, pready, pslverr;
   logic [3:0] ff = 4'hF, an = 4'h0, rrun = 4'hF, rxc, rlo, rfs, tlo, rv;
   logic [15:0] rxw = 16'h1234, txw = 16'h0000, lane, rxo, txo;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   int mismatches = 0, check_count = 0;
   // line outputs as seen on the pins
   wire [15:0] tx_pin = oe ? txo : 16'hZZZZ;
   initial forever #2.5 i_clk = ~i_clk;
   line_partner i_line_partner (.i_rx_run(rrun), .i_tx_run(1'b1), .i_word(rxw),
      .o_rx_clk(rxc), .o_lane(lane), .o_tx_clk(txc), .o_tx_frm(txf));
   line_lane_ctrl i_line_lane_ctrl (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .i_output_float_n(fl_n), .i_line_mode_select(mode), .i_drop_pointer_bypass(byp),
      .i_proc_bus_mode(proc), .i_monitor_interval_strobe(pm), .i_rx_clk(rxc),
      .i_rx_line_lane(lane), .i_tx_clk(txc), .i_tx_frame_sync_in(txf), .i_drop_clk(dci),
      .o_drop_clk(dck), .o_drop_clk_oe(dck_oe), .o_pin_oe(oe), .o_rx_clock_loop_out(rlo),
      .o_rx_frame_sync_out(rfs), .o_tx_clock_loop_out(tlo), .o_tx_line_lane(txo),
      .i_rx_frame_found(ff), .i_anomaly(an), .i_tx_word(txw), .o_rx_word(rxo),
      .o_rx_word_valid(rv), .o_tx_word_take(take), .o_ptr_gen_bypass(pbyp),
      .o_proc_bus_sync(psync), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   task cy(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // one comparison, counted
   task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x) begin
         $display("BAD %s exp %h got %h", nm, x, g);
         mismatches++;
      end
   endtask
   // apb transfer; data checked on reads, error flag always
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x,
      input logic xe);
      int n;
      n = 0;
      @(posedge i_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1;
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      if (!w) chk("prdata", x, q);
      chk("pslverr", xe, e);
      // no answer within the bound ends the run as a failure
      if (pready !== 1'b1) begin
         mismatches++;
         complete_run;
      end
   endtask
   function logic [15:0] pick(input int k);
      return k ? tx_pin : rxo;
   endfunction
   // bounded wait for receive word (k=0) or transmit lanes (k=1)
   task wt(input int k, input logic [15:0] x, input int lim);
      int n;
      n = 0;
      while (pick(k) !== x && n < lim) begin
         @(posedge i_clk);
         n++;
      end
      chk("lanes", x, pick(k));
      if (pick(k) !== x) complete_run;
   endtask
   task strobe;
      pm <= 1;
      cy(10);
      pm <= 0;
      cy(lane_map_pkg::PM_MIN_PERIOD_CYC);
   endtask
   task t_ctl;
      acc(0, lane_map_pkg::CTRL_OFS, 0, lane_map_pkg::CTRL_RESET, 0);
      acc(0, lane_map_pkg::STATUS_OFS, 0, 32'h0000_000E, 0);
      chk("bypass", 1, pbyp);
      chk("psync", 1, psync);
      chk("drop_oe", 1, dck_oe);
      acc(1, lane_map_pkg::STATUS_OFS, 32'h5, 0, 1);
      acc(0, 8'h40, 0, 0, 1);
      acc(1, lane_map_pkg::CTRL_OFS, 0, 0, 0);
      acc(0, lane_map_pkg::CTRL_OFS, 0, 0, 0);
      acc(1, lane_map_pkg::CTRL_OFS, 1, 0, 0);
      byp <= 0;
      proc <= 0;
      fl_n <= 0;
      dci <= 1;
      cy(10);
      chk("bypass", 0, pbyp);
      chk("psync", 0, psync);
      chk("drop_oe", 0, dck_oe);
      chk("float", 16'hZZZZ, tx_pin);
      fl_n <= 1;
      cy(10);
      chk("pin_oe", 1, oe);
      $display("test ctl done");
   endtask
   task t_rx;
      rxw <= 16'hA5C3;
      wt(0, 16'hA5C3, 400);
      chk("fsync", 4'h1, rfs);
      repeat (40) begin
         cy(1);
         chk("rloop", {4{rlo[0]}}, rlo);
         chk("tloop", {4{tlo[0]}}, tlo);
      end
      mode <= 1;
      rrun <= 4'hE;
      rxw <= 16'h3C96;
      wt(0, 16'h3C93, 400);
      chk("fsync", 4'hF, rfs);
      rrun <= 4'hF;
      $display("test rx done");
   endtask
   task t_tx;
      txw <= 16'h8001;
      wt(1, 16'h8001, 4000);
      mode <= 0;
      txw <= 16'h1E6B;
      wt(1, 16'h1E6B, 400);
      // let the mode pin settle through the sampler before reading status
      cy(8);
      acc(0, lane_map_pkg::STATUS_OFS, 0, 32'h0000_0038, 0);
      $display("test tx done");
   endtask
   task t_pm;
      strobe;
      an <= 4'h5;
      cy(3);
      an <= 4'h0;
      cy(2);
      strobe;
      acc(0, lane_map_pkg::PM_CH0_OFS, 0, 3, 0);
      acc(0, lane_map_pkg::PM_CH1_OFS, 0, 0, 0);
      acc(0, lane_map_pkg::PM_CH2_OFS, 0, 3, 0);
      strobe;
      acc(0, lane_map_pkg::PM_CH0_OFS, 0, 0, 0);
      $display("test pm done");
   endtask
   task t_rst;
      cy(1);
      i_arst_n <= 0;
      #1;
      chk("pin_oe", 0, oe);
      chk("rx_word", 0, rxo);
      cy(6);
      i_arst_n <= 1;
      cy(12);
      chk("pin_oe", 1, oe);
      $display("test reset done");
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      i_arst_n <= 0;
      cy(6);
      i_arst_n <= 1;
      cy(8);
      t_ctl;
      t_rx;
      t_tx;
      t_pm;
      t_rst;
      complete_run;
   end
endmodule

// ### dv/line_partner.sv
// serdes side: per-channel receive clocks, lanes, transmit clock and frame sync
module line_partner (
   // run enables, receive per channel
   input wire logic [3:0] i_rx_run,
   input wire logic i_tx_run,
   // word to present on the receive lanes
   input wire logic [15:0] i_word,
   // line pins
   output logic [3:0] o_rx_clk,
   output logic [15:0] o_lane,
   output logic o_tx_clk,
   output logic o_tx_frm
);
   timeunit 1ns;
   timeprecision 100ps;
   int n = 0;
   initial begin
      o_rx_clk = 4'h0;
      o_lane = 16'h0000;
      o_tx_clk = 1'b0;
      o_tx_frm = 1'b0;
   end
   // each channel clock has its own phase and stands still when stopped
   for (genvar g = 0; g < 4; g++) begin : ch
      initial begin
         #(3 + g * 17);
         forever #80 o_rx_clk[g] = i_rx_run[g] & ~o_rx_clk[g];
      end
      // lanes move on the falling edge, away from the capture edge
      always @(negedge o_rx_clk[g]) o_lane[4*g+:4] = i_word[4*g+:4];
   end
   // transmit clock, unrelated in phase
   initial begin
      #7;
      forever #80 o_tx_clk = i_tx_run & ~o_tx_clk;
   end
   // frame sync low for 40 periods, then high from then on
   always @(posedge o_tx_clk) begin
      n <= n + 1;
      o_tx_frm <= (n >= 40);
   end
endmodule

// ### hdl/lane_map_pkg.sv
// Contract
// - float input low puts every output pin into high impedance, except test data out.
// - active-low chip reset input at 0 resets the whole block asynchronously.
// - line mode select high gives four quarter-rate channels, low one full-rate channel.
// - drop pointer bypass high bypasses pointer generator, low enables it.
// - processor mode high selects synchronous bus operation, low asynchronous.
// - each rising monitor strobe edge copies internal counts into readable monitor registers.
// - the same strobe edge clears the internal anomaly counters for the next interval.
// - one transmit clock input clocks the whole transmit section in both modes.
// - full-rate mode: receive lanes 0..15 form one word, lane 0 least significant.
// - quarter-rate mode: four lanes per channel, lowest lane carries the channel's lsb.
// - full-rate drives only channel 1 frame sync; quarter-rate drives all four.
// - quarter-rate uses each channel's receive clock; full-rate uses only channel 1's.
// - receive loopbacks return own clock in quarter-rate, copies of channel 1 otherwise.
// - transmit clock output 1 carries the transmit clock in both modes.
// - full-rate mode: transmit lane 0 carries bit 0 of the word.
// - quarter-rate mode: four transmit lanes per channel, lowest lane carries lsb.
// - transmit clock outputs 2..4 copy channel 1 in full-rate, own clock in quarter-rate; the code copies the one transmit clock to all four in both modes.
// - with bypass the drop clock pin outputs channel 1 receive clock, else it is input.
package lane_map_pkg;
   localparam int NUM_CH = 4;
   localparam int LANES = 16;
   localparam int CH_LANES = 4;
   localparam int CNT_W = 16;
   // apb register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] PM_CH0_OFS = 8'h08;
   localparam logic [7:0] PM_CH1_OFS = 8'h0C;
   localparam logic [7:0] PM_CH2_OFS = 8'h10;
   localparam logic [7:0] PM_CH3_OFS = 8'h14;
   // control register fields and reset value
   localparam int CTRL_PM_EN_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   // status register fields
   localparam int ST_LINE_MODE_BIT = 0;
   localparam int ST_BYPASS_BIT = 1;
   localparam int ST_PROC_SYNC_BIT = 2;
   localparam int ST_FLOAT_N_BIT = 3;
   localparam int ST_TX_FRAME_OK_BIT = 4;
   localparam int ST_DROP_CLK_BIT = 5;
   // timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TX_FRAME_MIN_PERIODS = 32;
   localparam int RESET_MIN_PS = 26000;
   localparam int RESET_MIN_CYC = (RESET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PM_MIN_PERIOD_PS = 325000;
   localparam int PM_MIN_PERIOD_CYC = (PM_MIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [5:0] TX_RUN_MAX = 6'h3F;
   // positions inside the sampled pin vector
   localparam int P_RX_CLK = 0;
   localparam int P_TX_CLK = 4;
   localparam int P_TX_FRM = 5;
   localparam int P_PM = 6;
   localparam int P_FLOAT_N = 7;
   localparam int P_MODE = 8;
   localparam int P_BYPASS = 9;
   localparam int P_PROC = 10;
   localparam int P_DROP_CLK = 11;
   localparam int P_LANE = 12;
   localparam int PIN_W = 28;

   typedef enum logic [1:0] {
      TXF_WAIT_LOW = 2'b00,
      TXF_LOW_OK = 2'b01,
      TXF_HIGH = 2'b11,
      TXF_LOCKED = 2'b10
   } txf_state_e;

   typedef struct packed {
      logic float_n;
      logic quarter;
      logic bypass;
      logic proc_sync;
   } sys_ctl_s;
endpackage

// ### hdl/line_lane_ctrl.sv
module line_lane_ctrl (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // system control pins
   input wire logic i_output_float_n,
   input wire logic i_line_mode_select,
   input wire logic i_drop_pointer_bypass,
   input wire logic i_proc_bus_mode,
   input wire logic i_monitor_interval_strobe,
   // receive line pins
   input wire logic [3:0] i_rx_clk,
   input wire logic [15:0] i_rx_line_lane,
   // transmit line pins
   input wire logic i_tx_clk,
   input wire logic i_tx_frame_sync_in,
   // drop clock pin, three signals
   input wire logic i_drop_clk,
   output logic o_drop_clk,
   output logic o_drop_clk_oe,
   // line side outputs and their common enable
   output logic o_pin_oe,
   output logic [3:0] o_rx_clock_loop_out,
   output logic [3:0] o_rx_frame_sync_out,
   output logic [3:0] o_tx_clock_loop_out,
   output logic [15:0] o_tx_line_lane,
   // core side
   input wire logic [3:0] i_rx_frame_found,
   input wire logic [3:0] i_anomaly,
   input wire logic [15:0] i_tx_word,
   output logic [15:0] o_rx_word,
   output logic [3:0] o_rx_word_valid,
   output logic o_tx_word_take,
   output logic o_ptr_gen_bypass,
   output logic o_proc_bus_sync,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   localparam int NC = lane_map_pkg::NUM_CH;
   localparam int CL = lane_map_pkg::CH_LANES;

   logic rst_s1_r, rst_n;
   logic [lane_map_pkg::PIN_W-1:0] pins, lvl, rise;
   lane_map_pkg::sys_ctl_s ctl;
   logic [3:0] ch_rise;

   // reset asserts at once and releases on a clean edge
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   // every outside pin passes the same three-stage filter, keeping lanes aligned to clocks
   assign pins = {i_rx_line_lane, i_drop_clk, i_proc_bus_mode, i_drop_pointer_bypass,
                  i_line_mode_select, i_output_float_n, i_monitor_interval_strobe,
                  i_tx_frame_sync_in, i_tx_clk, i_rx_clk};

   pin_sampler #(.W(lane_map_pkg::PIN_W)) u_pins (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_pin(pins),
      .o_level(lvl),
      .o_rise(rise)
   );

   assign ctl.float_n = lvl[lane_map_pkg::P_FLOAT_N];
   assign ctl.quarter = lvl[lane_map_pkg::P_MODE];
   assign ctl.bypass = lvl[lane_map_pkg::P_BYPASS];
   assign ctl.proc_sync = lvl[lane_map_pkg::P_PROC];

   // capture edge per channel: own clock in quarter-rate, channel 1 clock in full-rate
   always_comb begin
      ch_rise = '0;
      for (int g = 0; g < NC; g++) begin
         ch_rise[g] = ctl.quarter ? rise[lane_map_pkg::P_RX_CLK + g]
                                  : rise[lane_map_pkg::P_RX_CLK];
      end
   end

   // ---------------- receive lanes, frame sync, loopback ----------------
   logic [15:0] rx_word_r, rx_word_nxt;
   logic [3:0] rx_val_r, rx_val_nxt, rx_loop_r, rx_loop_nxt, rx_frm_r, rx_frm_nxt;

   generate
      for (genvar g = 0; g < NC; g++) begin : g_rx
         always_comb begin
            // lane 4g+k is word bit 4g+k: lsb of each group is the lowest lane
            rx_word_nxt[g*CL +: CL] = ch_rise[g] ?
               lvl[lane_map_pkg::P_LANE + g*CL +: CL] : rx_word_r[g*CL +: CL];
            rx_val_nxt[g] = ch_rise[g];
            rx_loop_nxt[g] = ctl.quarter ? lvl[lane_map_pkg::P_RX_CLK + g]
                                         : lvl[lane_map_pkg::P_RX_CLK];
            rx_frm_nxt[g] = (g == 0 || ctl.quarter) ? i_rx_frame_found[g] : 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_word_r <= '0;
         rx_val_r <= '0;
         rx_loop_r <= '0;
         rx_frm_r <= '0;
      end else begin
         rx_word_r <= rx_word_nxt;
         rx_val_r <= rx_val_nxt;
         rx_loop_r <= rx_loop_nxt;
         rx_frm_r <= rx_frm_nxt;
      end
   end

   // ---------------- transmit frame sync qualification ----------------
   lane_map_pkg::txf_state_e txf_r, txf_nxt;
   logic [5:0] run_r, run_nxt;
   logic tx_edge, tx_frm;

   assign tx_edge = rise[lane_map_pkg::P_TX_CLK];
   assign tx_frm = lvl[lane_map_pkg::P_TX_FRM];

   // count low then high transmit clock periods; transmit runs once both are long enough
   always_comb begin
      txf_nxt = txf_r;
      run_nxt = run_r;
      if (tx_edge) begin
         run_nxt = (run_r == lane_map_pkg::TX_RUN_MAX) ? run_r : run_r + 6'h01;
         unique case (txf_r)
            lane_map_pkg::TXF_WAIT_LOW: begin
               if (tx_frm) begin
                  run_nxt = '0;
               end else if (run_nxt >= 6'(lane_map_pkg::TX_FRAME_MIN_PERIODS)) begin
                  txf_nxt = lane_map_pkg::TXF_LOW_OK;
               end
            end
            lane_map_pkg::TXF_LOW_OK: begin
               if (tx_frm) begin
                  txf_nxt = lane_map_pkg::TXF_HIGH;
                  run_nxt = 6'h01;
               end
            end
            lane_map_pkg::TXF_HIGH: begin
               if (!tx_frm) begin
                  txf_nxt = lane_map_pkg::TXF_WAIT_LOW;
                  run_nxt = 6'h01;
               end else if (run_nxt >= 6'(lane_map_pkg::TX_FRAME_MIN_PERIODS)) begin
                  txf_nxt = lane_map_pkg::TXF_LOCKED;
               end
            end
            lane_map_pkg::TXF_LOCKED: begin
               run_nxt = run_r;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         txf_r <= lane_map_pkg::TXF_WAIT_LOW;
         run_r <= '0;
      end else begin
         txf_r <= txf_nxt;
         run_r <= run_nxt;
      end
   end

   // ---------------- transmit lanes and clock outputs ----------------
   logic [15:0] tx_lane_r, tx_lane_nxt;
   logic [3:0] tx_loop_r, tx_loop_nxt;
   logic tx_take_r, tx_take_nxt;

   // one transmit clock serves every channel; word bit i goes to lane i in both modes
   always_comb begin
      tx_take_nxt = tx_edge && (txf_r == lane_map_pkg::TXF_LOCKED);
      tx_lane_nxt = tx_take_nxt ? i_tx_word : tx_lane_r;
      tx_loop_nxt = {NC{lvl[lane_map_pkg::P_TX_CLK]}};
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_lane_r <= '0;
         tx_loop_r <= '0;
         tx_take_r <= 1'b0;
      end else begin
         tx_lane_r <= tx_lane_nxt;
         tx_loop_r <= tx_loop_nxt;
         tx_take_r <= tx_take_nxt;
      end
   end

   // ---------------- system control outputs ----------------
   logic oe_r, drop_o_r, drop_oe_r, byp_r, proc_r;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         oe_r <= 1'b0;
         drop_o_r <= 1'b0;
         drop_oe_r <= 1'b0;
         byp_r <= 1'b0;
         proc_r <= 1'b0;
      end else begin
         oe_r <= ctl.float_n;
         drop_o_r <= lvl[lane_map_pkg::P_RX_CLK];
         drop_oe_r <= ctl.bypass & ctl.float_n;
         byp_r <= ctl.bypass;
         proc_r <= ctl.proc_sync;
      end
   end

   // ---------------- monitoring counters ----------------
   logic [3:0][15:0] cnt_r, cnt_nxt, pm_r, pm_nxt;
   logic pm_edge;
   logic [31:0] ctrl_r, ctrl_nxt;

   assign pm_edge = rise[lane_map_pkg::P_PM];

   // strobe edge latches counts and restarts counting; an anomaly in that cycle opens the new one
   generate
      for (genvar g = 0; g < NC; g++) begin : g_pm
         always_comb begin
            logic inc;
            inc = i_anomaly[g] & ctrl_r[lane_map_pkg::CTRL_PM_EN_BIT];
            pm_nxt[g] = pm_edge ? cnt_r[g] : pm_r[g];
            if (pm_edge) begin
               cnt_nxt[g] = {15'h0000, inc};
            end else if (inc && cnt_r[g] != 16'hFFFF) begin
               cnt_nxt[g] = cnt_r[g] + 16'h0001;
            end else begin
               cnt_nxt[g] = cnt_r[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         pm_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
         pm_r <= pm_nxt;
      end
   end

   // ---------------- apb slave, one wait state ----------------
   logic [31:0] rdata_r, rdata_nxt;
   logic ready_r, ready_nxt, err_r, err_nxt;

   function automatic logic mapped(input logic [7:0] a, input logic wr);
      mapped = (a == lane_map_pkg::CTRL_OFS) ||
               (!wr && (a == lane_map_pkg::STATUS_OFS || a == lane_map_pkg::PM_CH0_OFS ||
                        a == lane_map_pkg::PM_CH1_OFS || a == lane_map_pkg::PM_CH2_OFS ||
                        a == lane_map_pkg::PM_CH3_OFS));
   endfunction

   always_comb begin
      ready_nxt = psel && penable && !ready_r;
      err_nxt = ready_nxt && !mapped(paddr, pwrite);
      rdata_nxt = '0;
      ctrl_nxt = ctrl_r;
      if (ready_nxt && !pwrite) begin
         unique case (paddr)
            lane_map_pkg::CTRL_OFS: rdata_nxt = ctrl_r;
            lane_map_pkg::STATUS_OFS: begin
               rdata_nxt[lane_map_pkg::ST_LINE_MODE_BIT] = ctl.quarter;
               rdata_nxt[lane_map_pkg::ST_BYPASS_BIT] = ctl.bypass;
               rdata_nxt[lane_map_pkg::ST_PROC_SYNC_BIT] = ctl.proc_sync;
               rdata_nxt[lane_map_pkg::ST_FLOAT_N_BIT] = ctl.float_n;
               rdata_nxt[lane_map_pkg::ST_TX_FRAME_OK_BIT] = (txf_r == lane_map_pkg::TXF_LOCKED);
               rdata_nxt[lane_map_pkg::ST_DROP_CLK_BIT] = lvl[lane_map_pkg::P_DROP_CLK];
            end
            lane_map_pkg::PM_CH0_OFS: rdata_nxt = {16'h0000, pm_r[0]};
            lane_map_pkg::PM_CH1_OFS: rdata_nxt = {16'h0000, pm_r[1]};
            lane_map_pkg::PM_CH2_OFS: rdata_nxt = {16'h0000, pm_r[2]};
            lane_map_pkg::PM_CH3_OFS: rdata_nxt = {16'h0000, pm_r[3]};
            default: rdata_nxt = '0;
         endcase
      end
      // write lands on the edge where the master sees pready high
      if (psel && penable && ready_r && pwrite && paddr == lane_map_pkg::CTRL_OFS) begin
         ctrl_nxt = {31'h00000000, pwdata[lane_map_pkg::CTRL_PM_EN_BIT]};
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= '0;
         ready_r <= 1'b0;
         err_r <= 1'b0;
         ctrl_r <= lane_map_pkg::CTRL_RESET;
      end else begin
         rdata_r <= rdata_nxt;
         ready_r <= ready_nxt;
         err_r <= err_nxt;
         ctrl_r <= ctrl_nxt;
      end
   end

   // outputs
   assign o_pin_oe = oe_r;
   assign o_rx_word = rx_word_r;
   assign o_rx_word_valid = rx_val_r;
   assign o_rx_clock_loop_out = rx_loop_r;
   assign o_rx_frame_sync_out = rx_frm_r;
   assign o_tx_line_lane = tx_lane_r;
   assign o_tx_clock_loop_out = tx_loop_r;
   assign o_tx_word_take = tx_take_r;
   assign o_drop_clk = drop_o_r;
   assign o_drop_clk_oe = drop_oe_r;
   assign o_ptr_gen_bypass = byp_r;
   assign o_proc_bus_sync = proc_r;
   assign prdata = rdata_r;
   assign pready = ready_r;
   assign pslverr = err_r;

   // ---------------- checks ----------------
   float_oe_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      !ctl.float_n |=> !o_pin_oe && !o_drop_clk_oe) else $error("outputs driven while floated");
   reset_async_a: assert property (@(posedge i_clk)
      !i_arst_n |-> !rst_n) else $error("reset not applied at once");
   full_frame_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      !ctl.quarter |=> o_rx_frame_sync_out[3:1] == 3'b000) else $error("frame sync in full mode");
   full_capture_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      !ctl.quarter && rise[lane_map_pkg::P_RX_CLK] |=> o_rx_word_valid == 4'hF &&
      o_rx_word == $past(lvl[lane_map_pkg::P_LANE +: 16])) else $error("full word wrong");
   quarter_capture_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      ctl.quarter && rise[lane_map_pkg::P_RX_CLK + 2] |=> o_rx_word_valid[2] &&
      o_rx_word[11:8] == $past(lvl[lane_map_pkg::P_LANE + 8 +: 4])) else $error("group 3 wrong");
   rx_loop_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      !ctl.quarter |=> o_rx_clock_loop_out[3:1] == {3{o_rx_clock_loop_out[0]}})
      else $error("loopback copy wrong");
   tx_loop_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      1'b1 |=> o_tx_clock_loop_out == {4{$past(lvl[lane_map_pkg::P_TX_CLK])}})
      else $error("tx clock outputs wrong");
   tx_gate_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      o_tx_word_take |-> $past(txf_r) == lane_map_pkg::TXF_LOCKED) else $error("tx before lock");
   tx_lane_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      o_tx_word_take |-> o_tx_line_lane == $past(i_tx_word)) else $error("tx lane order");
   pm_latch_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      pm_edge |=> pm_r[1] == $past(cnt_r[1]) && cnt_r[1] <= 16'h0001)
      else $error("monitor latch wrong");
   ctl_pins_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      1'b1 |=> o_ptr_gen_bypass == $past(ctl.bypass) && o_proc_bus_sync == $past(ctl.proc_sync)
      && o_drop_clk == $past(lvl[lane_map_pkg::P_RX_CLK])) else $error("control pins wrong");
   apb_one_wait_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      psel && !penable ##1 psel && penable |-> !pready ##1 pready) else $error("apb wait wrong");

   tx_lock_c: cover property (@(posedge i_clk) disable iff (!rst_n)
      txf_r == lane_map_pkg::TXF_HIGH ##1 txf_r == lane_map_pkg::TXF_LOCKED);
   quarter_rx_c: cover property (@(posedge i_clk) disable iff (!rst_n)
      ctl.quarter && o_rx_word_valid == 4'h8);
   pm_edge_c: cover property (@(posedge i_clk) disable iff (!rst_n) pm_edge && cnt_r[0] != '0);
   apb_err_c: cover property (@(posedge i_clk) disable iff (!rst_n) pready && pslverr);
endmodule

// ### hdl/pin_sampler.sv
module pin_sampler #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // pins from outside the clock domain
   input wire logic [W-1:0] i_pin,
   // filtered level and rising-edge pulse
   output logic [W-1:0] o_level,
   output logic [W-1:0] o_rise
);
   logic [W-1:0] s1_r, s2_r, s3_r, level_r, rise_r;
   logic [W-1:0] level_nxt, rise_nxt;

   // a change counts once the second and third stages agree
   always_comb begin
      level_nxt = level_r;
      rise_nxt = '0;
      for (int i = 0; i < W; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            level_nxt[i] = s3_r[i];
         end
         rise_nxt[i] = level_nxt[i] & ~level_r[i];
      end
   end

   // three-stage chain and filtered level
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         level_r <= '0;
         rise_r <= '0;
      end else begin
         s1_r <= i_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         level_r <= level_nxt;
         rise_r <= rise_nxt;
      end
   end

   assign o_level = level_r;
   assign o_rise = rise_r;
endmodule
